// ### rtl/csc_core.sv
// sensor front-end configuration decode and fixed-point correction math
// Overview of operation
// - six-bit field sets zero-shift capacitance cancelling sensor offset.
// - five-bit field sets signal span; effective span is twice the value.
// - topology bit 0 selects differential mode, the default.
// - topology bit 1 selects single-ended mode; reference pin grounded unless guard or subtraction bit is set.
// - leakage bit in single-ended mode enables compensation, doubling range.
// - guard bit in single-ended mode drives reference pin like sense pin.
// - subtraction bit in single-ended mode charges reference oppositely.
// - temperature always converts at fixed 14-bit resolution.
// - two-bit field sets sensor resolution 12 to 18 bits, or 11 to 17 with leakage compensation.
// - one bit selects between two front-end noise modes.
// - math is 26-bit two's complement; coefficients sign-magnitude 1+23.
// - every product is scaled down by two to the twenty-third.
// - overflow and underflow saturate; all but the final temperature product are reported.
// - status bit 0 shows saturation of last measurement, else zero.
// - reciprocal bit inverts sensor value before correction math.
// - reciprocal stage is bypassed for raw measurements.
// - reciprocal output is 2^24 minus 2^46/raw, clamped to 26 bits.
// - curve bit picks parabolic (0) or S-shaped (1) correction.
// - stored coefficients are shifted left two bits when loaded.
// - gain term 2^23 plus tempcos; offset term 4*offset+raw+tempcos.
// - parabolic curve adds 2^23, quadratic, post offset, bounded positive.
// - S curve leaves the intermediate unclamped, uses absolute quadratic, adds 2^23, bounded positive.
// - temperature correction is always parabolic, bounded positive.
// - temperature coefficients and raw temperature span +-7fffff.
`timescale 1ns/1ps
module csc_core (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // configuration words from memory
    input wire logic [15:0] sensor_cfg,
    input wire logic [15:0] signal_cfg,
    input wire logic [15:0] interface_cfg,
    // sign-magnitude coefficients from memory
    input wire logic [23:0] coef_offset_s,
    input wire logic [23:0] coef_gain_s,
    input wire logic [23:0] coef_tcg,
    input wire logic [23:0] coef_tco,
    input wire logic [23:0] gain_tempco_sq_coef,
    input wire logic [23:0] offset_tempco_sq_coef,
    input wire logic [23:0] sensor_sq_coef,
    input wire logic [23:0] coef_sensor_shift,
    input wire logic [23:0] coef_gain_t,
    input wire logic [23:0] coef_offset_t,
    input wire logic [23:0] temp_sq_coef,
    input wire logic [23:0] coef_temp_shift,
    // measurement request
    input wire logic start,
    input wire logic raw_mode,
    input wire logic non_meas_cmd,
    input wire logic signed [25:0] sensor_raw,
    input wire logic signed [25:0] temp_raw,
    // front-end controls
    output logic [5:0] zero_shift_capacitance,
    output logic [5:0] signal_capacitance,
    output logic single_ended,
    output logic reference_pin_ground,
    output logic leakage_comp_en,
    output logic signal_range_double,
    output logic reference_pin_follow,
    output logic diff_charge_enable,
    output logic noise_mode,
    output logic [4:0] sensor_resolution,
    output logic [4:0] temp_resolution,
    output logic nonlin_curve_select,
    // results
    output logic busy,
    output logic done,
    output logic signed [25:0] corrected_result,
    output logic signed [25:0] temp_result,
    output logic sat_status
);
    csc_pkg::csc_state_type state_q, state_d;
    logic signed [25:0] s_q, s_d, k1_q, k1_d, k2_q, k2_d, zs_q, zs_d, zt_q, zt_d;
    logic signed [25:0] res_q, res_d, tres_q, tres_d;
    logic sat_q, sat_d, done_q, done_d, raw_q, raw_d;
    logic signed [25:0] c_off_s, c_gain_s, c_tcg, c_tco, c_sotg, c_soto, c_sots, c_shs;
    logic signed [25:0] c_gain_t, c_off_t, c_sott, c_sht;
    logic signed [25:0] ma [0:9];
    logic signed [25:0] mb [0:9];
    logic signed [25:0] my [0:9];
    logic [9:0] msat;
    logic signed [47:0] rq;
    logic signed [47:0] rv;
    logic signed [25:0] recip;
    logic rsat;
    logic [26:0] sum2, sum3, sum7, sum8;

    // sign-magnitude to two's complement, msb aligned to the 26-bit register
    function automatic logic signed [25:0] load_coef(input logic [23:0] c);
        logic signed [25:0] m;
        m = {c[22:0], 3'h0} >>> 1;
        return c[23] ? -m : m;
    endfunction

    // saturating add of up to three terms
    function automatic logic [26:0] sadd(input logic signed [25:0] a, input logic signed [25:0] b,
        input logic signed [25:0] c);
        logic signed [27:0] t;
        t = 28'(a) + 28'(b) + 28'(c);
        if (t > 28'(csc_pkg::MAXV))
            return {1'b1, csc_pkg::MAXV};
        else if (t < 28'(csc_pkg::MINV))
            return {1'b1, csc_pkg::MINV};
        else
            return {1'b0, t[25:0]};
    endfunction

    // clamp at zero for results bounded to the positive range
    function automatic logic [26:0] pos(input logic [26:0] v);
        if (v[25])
            return {1'b1, 26'h0000000};
        else
            return v;
    endfunction

    // front-end decode, purely combinational from the configuration words
    assign zero_shift_capacitance = sensor_cfg[csc_pkg::SHIFT_CAP_LSB +: csc_pkg::SHIFT_CAP_W];
    assign signal_capacitance = {sensor_cfg[csc_pkg::CAP_RANGE_LSB +: csc_pkg::CAP_RANGE_W], 1'b0};
    assign single_ended = sensor_cfg[csc_pkg::SENSECAP_BIT];
    assign reference_pin_ground = single_ended & ~reference_pin_follow & ~diff_charge_enable;
    assign leakage_comp_en = single_ended & sensor_cfg[csc_pkg::LEAKAGE_BIT];
    assign signal_range_double = leakage_comp_en;
    assign reference_pin_follow = single_ended & signal_cfg[csc_pkg::SHIELD_BIT];
    assign diff_charge_enable = single_ended & signal_cfg[csc_pkg::SUBTRACT_BIT];
    assign noise_mode = sensor_cfg[csc_pkg::NOISE_MODE_BIT];
    // leakage compensation costs one effective bit of resolution
    assign sensor_resolution = csc_pkg::RES_BASE + {2'h0, sensor_cfg[csc_pkg::ADC_BITS_LSB +: 2], 1'b0}
        - {4'h0, leakage_comp_en};
    assign temp_resolution = 5'(csc_pkg::TEMP_RES);
    assign nonlin_curve_select = interface_cfg[csc_pkg::CURVE_BIT];

    // coefficient loading
    assign c_off_s = load_coef(coef_offset_s);
    assign c_gain_s = load_coef(coef_gain_s);
    assign c_tcg = load_coef(coef_tcg);
    assign c_tco = load_coef(coef_tco);
    assign c_sotg = load_coef(gain_tempco_sq_coef);
    assign c_soto = load_coef(offset_tempco_sq_coef);
    assign c_sots = load_coef(sensor_sq_coef);
    assign c_shs = load_coef(coef_sensor_shift);
    assign c_gain_t = load_coef(coef_gain_t);
    assign c_off_t = load_coef(coef_offset_t);
    assign c_sott = load_coef(temp_sq_coef);
    assign c_sht = load_coef(coef_temp_shift);

    // reciprocal stage; a zero raw value clamps to the negative limit
    always_comb
    begin
        rq = 48'sh0;
        rsat = 1'b0;
        if (sensor_raw == 26'sh0)
            rq = csc_pkg::RECIP_NUM;
        else
            rq = csc_pkg::RECIP_NUM / 48'(sensor_raw);
        rv = csc_pkg::RECIP_BIAS - rq;
        recip = rv[25:0];
        if (rv > 48'(csc_pkg::MAXV))
        begin
            recip = csc_pkg::MAXV;
            rsat = 1'b1;
        end
        else if (rv < 48'(csc_pkg::MINV))
        begin
            recip = csc_pkg::MINV;
            rsat = 1'b1;
        end
    end

    // multiplier operands; loads already hold the factor of four, sums keep their overflow flag
    always_comb
    begin
        sum2 = sadd(my[0], c_tcg, 26'sh0);
        sum3 = sadd(my[1], c_tco, 26'sh0);
        sum7 = sadd(my[6], csc_pkg::ONE, 26'sh0);
        sum8 = sadd(temp_raw, c_off_t, 26'sh0);
        ma[0] = c_sotg;
        mb[0] = temp_raw;
        ma[1] = c_soto;
        mb[1] = temp_raw;
        ma[2] = temp_raw;
        mb[2] = sum2[25:0];
        ma[3] = temp_raw;
        mb[3] = sum3[25:0];
        ma[4] = c_gain_s;
        mb[4] = k1_q;
        ma[5] = my[4];
        mb[5] = k2_q;
        ma[6] = c_sots;
        mb[6] = (nonlin_curve_select && zs_q[25]) ? -zs_q : zs_q;
        ma[7] = zs_q;
        mb[7] = sum7[25:0];
        ma[8] = c_gain_t;
        mb[8] = sum8[25:0];
        ma[9] = c_sott;
        mb[9] = zt_q;
    end

    // ten scaled multipliers, each wired to one fixed product
    genvar gi;
    generate
        for (gi = 0; gi < 10; gi++)
        begin : g_mul
            csc_mul csc_mul_inst (
                .a(ma[gi]),
                .b(mb[gi]),
                .y(my[gi]),
                .sat(msat[gi])
            );
        end
    endgenerate

    // correction sequence: pre-step, gain/offset terms, intermediate value, output
    always_comb
    begin
        logic [26:0] t0;
        logic [26:0] t1;
        logic [26:0] t2;
        t0 = 27'h0;
        t1 = 27'h0;
        t2 = 27'h0;
        state_d = state_q;
        s_d = s_q;
        k1_d = k1_q;
        k2_d = k2_q;
        zs_d = zs_q;
        zt_d = zt_q;
        res_d = res_q;
        tres_d = tres_q;
        sat_d = sat_q;
        raw_d = raw_q;
        done_d = 1'b0;
        case (state_q)
            csc_pkg::ST_IDLE:
            begin
                if (start)
                begin
                    raw_d = raw_mode;
                    sat_d = 1'b0;
                    state_d = csc_pkg::ST_PRE;
                end
                else if (non_meas_cmd)
                    sat_d = 1'b0;
            end
            csc_pkg::ST_PRE:
            begin
                if (interface_cfg[csc_pkg::RECIP_BIT] && !raw_q)
                begin
                    s_d = recip;
                    sat_d = sat_q | rsat;
                end
                else
                    s_d = sensor_raw;
                state_d = raw_q ? csc_pkg::ST_OUT : csc_pkg::ST_K;
            end
            csc_pkg::ST_K:
            begin
                t0 = sadd(csc_pkg::ONE, my[2], 26'sh0);
                t1 = sadd(c_off_s, s_q, my[3]);
                t2 = pos(sadd(my[8], csc_pkg::ONE, 26'sh0));
                k1_d = t0[25:0];
                k2_d = t1[25:0];
                zt_d = t2[25:0];
                sat_d = sat_q | t0[26] | t1[26] | t2[26] | (|msat[3:0]) | msat[8]
                    | sum2[26] | sum3[26] | sum8[26];
                state_d = csc_pkg::ST_Z;
            end
            csc_pkg::ST_Z:
            begin
                if (nonlin_curve_select)
                    t0 = {1'b0, my[5]};
                else
                    t0 = pos(sadd(my[5], csc_pkg::ONE, 26'sh0));
                zs_d = t0[25:0];
                sat_d = sat_q | t0[26] | (|msat[5:4]);
                state_d = csc_pkg::ST_OUT;
            end
            csc_pkg::ST_OUT:
            begin
                if (raw_q)
                    res_d = s_q;
                else
                begin
                    if (nonlin_curve_select)
                        t0 = pos(sadd(my[7], csc_pkg::ONE, c_shs));
                    else
                        t0 = pos(sadd(my[7], c_shs, 26'sh0));
                    res_d = t0[25:0];
                    sat_d = sat_q | t0[26] | (|msat[7:6]) | sum7[26];
                end
                // temperature: quadratic then post shift, always parabolic
                t2 = sadd(my[9], csc_pkg::ONE, 26'sh0);
                t1 = pos(sadd(csc_mul_fn(zt_q, t2[25:0]), c_sht, 26'sh0));
                tres_d = raw_q ? temp_raw : t1[25:0];
                if (!raw_q)
                    sat_d = sat_d | t1[26] | t2[26] | msat[9];
                done_d = 1'b1;
                state_d = csc_pkg::ST_IDLE;
            end
            default:
                state_d = csc_pkg::ST_IDLE;
        endcase
    end

    // scaled multiply for the final temperature product
    function automatic logic signed [25:0] csc_mul_fn(input logic signed [25:0] a, input logic signed [25:0] b);
        logic signed [51:0] p;
        p = (52'(a) * 52'(b)) >>> csc_pkg::FRAC;
        if (p > 52'(csc_pkg::MAXV))
            return csc_pkg::MAXV;
        else if (p < 52'(csc_pkg::MINV))
            return csc_pkg::MINV;
        else
            return p[25:0];
    endfunction

    // state and result registers
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            state_q <= csc_pkg::ST_IDLE;
            s_q <= 26'sh0;
            k1_q <= 26'sh0;
            k2_q <= 26'sh0;
            zs_q <= 26'sh0;
            zt_q <= 26'sh0;
            res_q <= 26'sh0;
            tres_q <= 26'sh0;
            sat_q <= 1'b0;
            raw_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            s_q <= s_d;
            k1_q <= k1_d;
            k2_q <= k2_d;
            zs_q <= zs_d;
            zt_q <= zt_d;
            res_q <= res_d;
            tres_q <= tres_d;
            sat_q <= sat_d;
            raw_q <= raw_d;
            done_q <= done_d;
        end
    end

    // outputs
    assign busy = (state_q != csc_pkg::ST_IDLE);
    assign done = done_q;
    assign corrected_result = res_q;
    assign temp_result = tres_q;
    assign sat_status = sat_q & ~busy;
endmodule // csc_core

// ### rtl/csc_mul.sv
// scaled saturating multiplier: a*b / 2^23 clamped to 26-bit signed
`timescale 1ns/1ps
module csc_mul (
    // operands
    input wire logic signed [25:0] a,
    input wire logic signed [25:0] b,
    // result
    output logic signed [25:0] y,
    output logic sat
);
    logic signed [51:0] prod;
    logic signed [51:0] shf;
    // product scaled down then clamped so overflow never wraps
    always_comb
    begin
        prod = a * b;
        shf = prod >>> csc_pkg::FRAC;
        sat = 1'b0;
        y = shf[25:0];
        if (shf > 52'(csc_pkg::MAXV))
        begin
            y = csc_pkg::MAXV;
            sat = 1'b1;
        end
        else if (shf < 52'(csc_pkg::MINV))
        begin
            y = csc_pkg::MINV;
            sat = 1'b1;
        end
    end
endmodule // csc_mul

// ### rtl/csc_pkg.sv
// package: configuration field positions, widths and math constants for the sensor correction block
package csc_pkg;
    // configuration word 12h field positions
    localparam int SHIFT_CAP_LSB = 0;
    localparam int SHIFT_CAP_W = 6;
    localparam int ADC_BITS_LSB = 6;
    localparam int NOISE_MODE_BIT = 8;
    localparam int CAP_RANGE_LSB = 9;
    localparam int CAP_RANGE_W = 5;
    localparam int LEAKAGE_BIT = 14;
    localparam int SENSECAP_BIT = 15;
    // configuration word 19h field positions
    localparam int SHIELD_BIT = 4;
    localparam int SUBTRACT_BIT = 3;
    // configuration word 02h field positions
    localparam int RECIP_BIT = 11;
    localparam int CURVE_BIT = 15;
    // datapath widths and constants
    localparam int DW = 26;
    localparam int FRAC = 23;
    localparam int TEMP_RES = 14;
    localparam logic [4:0] RES_BASE = 5'h0c;
    localparam logic signed [25:0] ONE = 26'sh0800000;
    localparam logic signed [25:0] MAXV = 26'sh1ffffff;
    localparam logic signed [25:0] MINV = -26'sh2000000;
    localparam logic signed [47:0] RECIP_NUM = 48'sh400000000000;
    localparam logic signed [47:0] RECIP_BIAS = 48'sh000001000000;
    // sequence states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PRE = 3'b001,
        ST_K = 3'b010,
        ST_Z = 3'b011,
        ST_OUT = 3'b100
    } csc_state_type;
endpackage

// ### tb/csc_core_chk.sv
// checker: front-end decode and measurement timing properties of the correction core
`timescale 1ns/1ps
module csc_core_chk (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // configuration and request
    input wire logic [15:0] sensor_cfg,
    input wire logic [15:0] signal_cfg,
    input wire logic start,
    input wire logic non_meas_cmd,
    // front-end controls
    input wire logic [5:0] zero_shift_capacitance,
    input wire logic [5:0] signal_capacitance,
    input wire logic single_ended,
    input wire logic reference_pin_ground,
    input wire logic leakage_comp_en,
    input wire logic signal_range_double,
    input wire logic reference_pin_follow,
    input wire logic diff_charge_enable,
    input wire logic [4:0] sensor_resolution,
    input wire logic [4:0] temp_resolution,
    // results
    input wire logic busy,
    input wire logic done,
    input wire logic signed [25:0] corrected_result,
    input wire logic sat_status
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    // decode of the front-end fields
    a_shift_cap: assert property (zero_shift_capacitance == sensor_cfg[5:0]) else $error("shift cap wrong");
    a_span_double: assert property (signal_capacitance == {sensor_cfg[13:9], 1'b0})
        else $error("signal span not doubled");
    a_diff_default: assert property (!sensor_cfg[15] |-> !single_ended && !reference_pin_ground)
        else $error("differential mode wrong");
    a_single_ground: assert property (
        sensor_cfg[15] && signal_cfg[4:3] == 2'b00 |-> single_ended && reference_pin_ground)
        else $error("single-ended mode wrong");
    a_leak_range: assert property (
        leakage_comp_en == (sensor_cfg[15] && sensor_cfg[14]) && signal_range_double == leakage_comp_en)
        else $error("leakage compensation gating wrong");
    a_guard_follow: assert property (reference_pin_follow == (sensor_cfg[15] && signal_cfg[4]))
        else $error("guard drive gating wrong");
    a_sub_charge: assert property (diff_charge_enable == (sensor_cfg[15] && signal_cfg[3]))
        else $error("subtraction gating wrong");
    a_temp_fixed: assert property (temp_resolution == 5'h0e) else $error("temperature resolution moved");
    a_res_decode: assert property (
        sensor_resolution == 5'h0c + {2'b00, sensor_cfg[7:6], 1'b0} - {4'h0, leakage_comp_en})
        else $error("resolution decode wrong");
    // measurement sequencing; raw finishes sooner than corrected
    a_done_bound: assert property (start && !busy |-> ##[3:6] done) else $error("no completion in time");
    a_sat_clear: assert property (non_meas_cmd && !busy |=> !sat_status)
        else $error("saturation kept after command");
    a_done_finish: assert property ($fell(busy) |-> done) else $error("busy dropped without done");
    a_result_hold: assert property (!done |-> $stable(corrected_result))
        else $error("result moved without done");
endmodule // csc_core_chk

bind csc_core csc_core_chk csc_core_chk_inst (.core_clk(core_clk), .reset(reset), .sensor_cfg(sensor_cfg),
    .signal_cfg(signal_cfg), .start(start), .zero_shift_capacitance(zero_shift_capacitance),
    .signal_capacitance(signal_capacitance), .single_ended(single_ended), .reference_pin_ground(reference_pin_ground),
    .leakage_comp_en(leakage_comp_en), .signal_range_double(signal_range_double),
    .reference_pin_follow(reference_pin_follow), .diff_charge_enable(diff_charge_enable),
    .sensor_resolution(sensor_resolution), .temp_resolution(temp_resolution), .busy(busy), .done(done),
    .corrected_result(corrected_result), .sat_status(sat_status), .non_meas_cmd(non_meas_cmd));

// ### tb/csc_nvm_model.sv
// partner: configuration and coefficient memory that feeds the correction core
`timescale 1ns/1ps
module csc_nvm_model (
    // clock
    input wire logic core_clk,
    input wire logic reset,
    // write port used by the bench to program words
    input wire logic wr_en,
    input wire logic [3:0] wr_addr,
    input wire logic [23:0] wr_data,
    // stored words, seen by the core as plain levels
    output logic [14:0][23:0] word_q
);
    logic [14:0][23:0] word_d;

    // next contents: one word replaced per write; words only move between measurements
    always_comb
    begin
        word_d = word_q;
        if (wr_en)
        begin
            word_d[wr_addr] = wr_data;
        end
    end

    // registered so the core never sees a word change in mid-cycle; reset clears unknown words
    always_ff @(posedge core_clk)
    begin
        if (reset)
            word_q <= '0;
        else
            word_q <= word_d;
    end
endmodule // csc_nvm_model

// ### tb/test_capacitive_sensor_calibration_math.sv
// testbench: programs memory words, requests measurements and compares decode and corrected results
`timescale 1ns/1ps
module test_capacitive_sensor_calibration_math;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic wr_en = 1'b0;
    logic [3:0] wr_addr = 4'h0;
    logic [23:0] wr_data = 24'h000000;
    logic [14:0][23:0] nvm;
    logic start = 1'b0;
    logic raw_mode = 1'b0;
    logic non_meas_cmd = 1'b0;
    logic signed [25:0] sensor_raw = 26'h0000000;
    logic signed [25:0] temp_raw = 26'h0100000;
    logic [5:0] zero_shift_capacitance, signal_capacitance;
    logic single_ended, reference_pin_ground, leakage_comp_en, signal_range_double, reference_pin_follow;
    logic diff_charge_enable, noise_mode, nonlin_curve_select, busy, done, sat_status;
    logic [4:0] sensor_resolution, temp_resolution;
    logic signed [25:0] corrected_result, temp_result;
    logic [52:0] exp_q [$];
    logic [52:0] note;
    int miscompares = 0;
    int n_checks = 0;

    always #10 core_clk = ~core_clk;

    csc_nvm_model csc_nvm_model_inst (.core_clk(core_clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .reset(reset), .word_q(nvm));

    csc_core csc_core_inst (.core_clk(core_clk), .reset(reset), .sensor_cfg(nvm[0][15:0]), .signal_cfg(nvm[1][15:0]),
        .interface_cfg(nvm[2][15:0]), .coef_offset_s(nvm[3]), .coef_gain_s(nvm[4]), .coef_tcg(nvm[5]),
        .coef_tco(nvm[6]), .gain_tempco_sq_coef(nvm[7]), .offset_tempco_sq_coef(nvm[8]), .sensor_sq_coef(nvm[9]),
        .coef_sensor_shift(nvm[10]), .coef_gain_t(nvm[11]), .coef_offset_t(nvm[12]), .temp_sq_coef(nvm[13]),
        .coef_temp_shift(nvm[14]), .start(start), .raw_mode(raw_mode), .non_meas_cmd(non_meas_cmd),
        .sensor_raw(sensor_raw), .temp_raw(temp_raw), .zero_shift_capacitance(zero_shift_capacitance),
        .signal_capacitance(signal_capacitance), .single_ended(single_ended),
        .reference_pin_ground(reference_pin_ground), .leakage_comp_en(leakage_comp_en),
        .signal_range_double(signal_range_double),
        .reference_pin_follow(reference_pin_follow), .diff_charge_enable(diff_charge_enable), .noise_mode(noise_mode),
        .sensor_resolution(sensor_resolution), .temp_resolution(temp_resolution),
        .nonlin_curve_select(nonlin_curve_select), .busy(busy), .done(done), .corrected_result(corrected_result),
        .temp_result(temp_result), .sat_status(sat_status));

    task automatic check(input logic [25:0] seen, input logic [25:0] expv);
        n_checks++;
        if (seen !== expv)
        begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic mem_wr(input logic [3:0] a, input logic [23:0] d);
        @(posedge core_clk);
        wr_en <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask

    // h above one keeps start high into the busy cycles, where it must be ignored
    task automatic measure(input logic r, input logic [25:0] s, input logic [25:0] t, input logic [52:0] e,
        input int h);
        int i;
        exp_q.push_back(e);
        @(posedge core_clk);
        start <= 1'b1;
        raw_mode <= r;
        sensor_raw <= s;
        temp_raw <= t;
        repeat (h) @(posedge core_clk);
        start <= 1'b0;
        for (i = 0; i < 20 && done !== 1'b1; i++)
            @(posedge core_clk);
        if (i == 20)
        begin
            miscompares++;
            tally_and_finish;
        end
    endtask

    // one coefficient changed, then a corrected measurement with temperature raw fixed at 1/8
    task automatic mc(input logic [3:0] a, input logic [23:0] c, input logic [25:0] s, input logic [25:0] ec,
        input logic [25:0] et, input logic sat);
        mem_wr(a, c);
        measure(1'b0, s, 26'h0100000, {ec, et, sat}, 1);
    endtask

    task automatic fe_check(input logic [15:0] sc, input logic [15:0] gc, input logic [15:0] ic);
        logic se;
        logic lk;
        se = sc[15];
        lk = se & sc[14];
        check(26'(zero_shift_capacitance), 26'(sc[5:0]));
        check(26'(signal_capacitance), 26'({sc[13:9], 1'b0}));
        check(26'({single_ended, reference_pin_follow, diff_charge_enable}),
            26'({se, se & gc[4], se & gc[3]}));
        if (gc[4:3] == 2'b00)
            check(26'(reference_pin_ground), 26'(se));
        check(26'({leakage_comp_en, signal_range_double}), 26'({lk, lk}));
        check(26'(sensor_resolution), 26'(5'h0c + {2'b00, sc[7:6], 1'b0} - {4'h0, lk}));
        check(26'(temp_resolution), 26'h000000e);
        check(26'({noise_mode, nonlin_curve_select}), 26'({sc[8], ic[15]}));
    endtask

    // completion monitor: an unexpected done finds an empty queue and an all-ones note
    always @(posedge core_clk)
    begin
        if (done === 1'b1)
        begin
            note = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
            check(corrected_result, note[52:27]);
            check(temp_result, note[26:1]);
            check(26'(sat_status), 26'(note[0]));
        end
    end

    initial
    begin
        logic [15:0] sc, gc, ic;
        logic [25:0] a, b;
        int k;
        void'($urandom(63722));
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        // unity gains for sensor and temperature, everything else zero
        for (k = 0; k < 15; k++)
            mem_wr(k[3:0], (k == 4 || k == 11) ? 24'h200000 : 24'h000000);
        for (k = 0; k < 24; k++)
        begin
            sc = 16'($urandom());
            gc = 16'($urandom());
            ic = 16'($urandom());
            sc[7:6] = k[1:0];
            mem_wr(4'h0, {8'h00, sc});
            mem_wr(4'h1, {8'h00, gc});
            mem_wr(4'h2, {8'h00, ic});
            #1;
            fe_check(sc, gc, ic);
        end
        mem_wr(4'h0, 24'h000000);
        mem_wr(4'h1, 24'h000000);
        // raw requests must skip reciprocal and curve even when both are enabled
        mem_wr(4'h2, 24'h008800);
        for (k = 0; k < 8; k++)
        begin
            a = 26'($urandom());
            b = 26'($urandom());
            measure(1'b1, a, b, {a, b, 1'b0}, 1);
        end
        mc(4'h2, 24'h000000, 26'h0100000, 26'h0900000, 26'h0900000, 1'b0);
        measure(1'b0, 26'h0100000, 26'h0100000, {26'h0900000, 26'h0900000, 1'b0}, 2);
        mc(4'h3, 24'h040000, 26'h0000000, 26'h0900000, 26'h0900000, 1'b0);
        mem_wr(4'h3, 24'h000000);
        mc(4'h5, 24'h200000, 26'h0800000, 26'h1100000, 26'h0900000, 1'b0);
        mem_wr(4'h5, 24'h000000);
        mc(4'h6, 24'h200000, 26'h0000000, 26'h0900000, 26'h0900000, 1'b0);
        mem_wr(4'h6, 24'h000000);
        mc(4'h9, 24'h200000, 26'h0000000, 26'h1000000, 26'h0900000, 1'b0);
        mc(4'h9, 24'h200000, 26'h3c00000, 26'h0600000, 26'h0900000, 1'b0);
        mc(4'h2, 24'h008000, 26'h3c00000, 26'h0200000, 26'h0900000, 1'b0);
        mem_wr(4'h2, 24'h000000);
        mc(4'h9, 24'ha00000, 26'h0000000, 26'h0000000, 26'h0900000, 1'b0);
        mc(4'h9, 24'h200000, 26'h1000000, 26'h1ffffff, 26'h0900000, 1'b1);
        #1;
        check(26'(sat_status), 26'h0000001);
        @(posedge core_clk);
        non_meas_cmd <= 1'b1;
        @(posedge core_clk);
        non_meas_cmd <= 1'b0;
        @(posedge core_clk);
        #1;
        check(26'(sat_status), 26'h0000000);
        mem_wr(4'h9, 24'h000000);
        mc(4'h2, 24'h000800, 26'h0400000, 26'h0800000, 26'h0900000, 1'b0);
        mem_wr(4'h2, 24'h000000);
        mc(4'hd, 24'h200000, 26'h0100000, 26'h0900000, 26'h1320000, 1'b0);
        mc(4'hc, 24'h840000, 26'h0100000, 26'h0900000, 26'h1000000, 1'b0);
        repeat (4) @(posedge core_clk);
        tally_and_finish;
    end
endmodule // test_capacitive_sensor_calibration_math
